// *** hdl/hrc_pkg.sv ***
/*
 * Constants and types for the host request coherence decoder.
 * Assumes a single 250 MHz core clock and an APB register slave.
 */
// Operation
// - selector 00 writes host state from metadata_value, 11 ignores it, others reserved
// - host state invalid lets the engine grant the device exclusive ownership locally
// - line_invalidate, invalid state, snoop_invalidate flushes a cached line to memory
// - host state any: the device gets no copy before a request goes to the host
// - host state shared: shared or current copies local, exclusive needs the host
// - snoop_kind 000 is no snoop; 1xx is reserved and never issued
// - snoop_shared hands over at least a shared copy, exclusive allowed
// - snoop_current returns the current value and leaves device state alone
// - snoop_invalidate makes the line exclusive for the requester, snooping caches
// - line_read, any, snoop_invalidate answers exclusive completion plus line data
// - line_read, shared, snoop_shared answers shared or exclusive completion plus data
// - line_read, no metadata, snoop_current answers plain completion plus data
// - line_read, no metadata, snoop_invalidate invalidates device copy, plain plus data
// - invalidate (or non-temporal), any, snoop_invalidate answers exclusive completion only
// - line_invalidate, invalid, snoop_invalidate invalidates and answers plain only
// - read_for_data with snoop_shared answers shared or exclusive completion plus data
// - read_for_data ignores metadata fields and moves host state invalid to any
// - opcodes 0000, 0001, 0010, 1001 are invalidate, read, read_for_data, non-temporal
`default_nettype none
package hrc_pkg;
    // ----------------------------------------------------------------
    // request field encodings
    // ----------------------------------------------------------------
    localparam logic [3:0] OP_LINE_INV = 4'h0;
    localparam logic [3:0] OP_LINE_RD = 4'h1;
    localparam logic [3:0] OP_RD_DATA = 4'h2;
    localparam logic [3:0] OP_INV_NT = 4'h9;
    localparam logic [1:0] SEL_HOST_STATE = 2'h0;
    localparam logic [1:0] SEL_NOOP = 2'h3;
    localparam logic [1:0] META_I = 2'h0;
    localparam logic [1:0] META_A = 2'h2;
    localparam logic [1:0] META_S = 2'h3;
    localparam logic [2:0] SNP_NONE = 3'h0;
    localparam logic [2:0] SNP_SHARED = 3'h1;
    localparam logic [2:0] SNP_CUR = 3'h2;
    localparam logic [2:0] SNP_INV = 3'h3;
    // ----------------------------------------------------------------
    // completions and device cache states
    // ----------------------------------------------------------------
    localparam logic [1:0] NDR_CMP = 2'h0;
    localparam logic [1:0] NDR_CMP_S = 2'h1;
    localparam logic [1:0] NDR_CMP_E = 2'h2;
    localparam logic [1:0] NDR_ERR = 2'h3;
    localparam logic [1:0] CS_I = 2'h0;
    localparam logic [1:0] CS_S = 2'h1;
    localparam logic [1:0] CS_E = 2'h2;
    localparam logic [1:0] CS_M = 2'h3;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ERRCNT = 8'h08;
    localparam logic [7:0] REG_PEEK = 8'h0c;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_EXCL_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int STAT_ERR_LSB = 16;
    localparam int PEEK_IDX_LSB = 8;

    typedef enum logic [1:0] {ACT_KEEP, ACT_SHARE, ACT_INVAL} hrc_act_type;
    typedef struct packed {
        logic legal;
        logic [1:0] no_data_response_channel;
        logic data;
        hrc_act_type act;
        logic meta_wr;
        logic [1:0] meta_val;
    } hrc_action_type;
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RESP = 2'b10} hrc_state_type;
endpackage
`default_nettype wire

// *** hdl/hrc_dec_if.sv ***
/*
 * Carrier between the request engine and its field decoder.
 * Assumes both ends sit on the same clock; the decode is combinational.
 */
`default_nettype none
interface hrc_dec_if;
    import hrc_pkg::*;
    logic [3:0] opcode;
    logic [1:0] sel;
    logic [1:0] mval;
    logic [2:0] snp;
    logic [1:0] meta_cur;
    logic prefer_excl;
    hrc_action_type act;
    modport engine (output opcode, sel, mval, snp, meta_cur, prefer_excl, input act);
    modport decoder (input opcode, sel, mval, snp, meta_cur, prefer_excl, output act);
endinterface
`default_nettype wire

// *** hdl/hrc_decode.sv ***
/*
 * Combinational decode of one host request into a completion and an action.
 * Assumes the engine supplies the current host state of the addressed line.
 */
`default_nettype none
module hrc_decode
    import hrc_pkg::*;
(
    hrc_dec_if.decoder d
);
    always_comb begin
        d.act = '0;
        d.act.act = ACT_KEEP;
        d.act.no_data_response_channel = NDR_ERR;
        // reserved snoop kinds match no arm below; read_for_data ignores selector and value, and the no-op selector arms ignore the value
        case (d.opcode)
            OP_LINE_RD: begin
                if (d.sel == SEL_HOST_STATE && d.mval == META_A && d.snp == SNP_INV) begin
                    d.act = '{1'b1, NDR_CMP_E, 1'b1, ACT_INVAL, 1'b1, META_A};
                end else if (d.sel == SEL_HOST_STATE && d.mval == META_S &&
                             d.snp == SNP_SHARED) begin
                    // an exclusive grant must pull the device copy, a shared one only demotes it
                    d.act = '{1'b1, d.prefer_excl ? NDR_CMP_E : NDR_CMP_S, 1'b1,
                              d.prefer_excl ? ACT_INVAL : ACT_SHARE, 1'b1, META_S};
                end else if (d.sel == SEL_NOOP && d.snp == SNP_CUR) begin
                    d.act = '{1'b1, NDR_CMP, 1'b1, ACT_KEEP, 1'b0, META_I};
                end else if (d.sel == SEL_NOOP && d.snp == SNP_INV) begin
                    d.act = '{1'b1, NDR_CMP, 1'b1, ACT_INVAL, 1'b0, META_I};
                end
            end
            OP_LINE_INV, OP_INV_NT: begin
                if (d.sel == SEL_HOST_STATE && d.snp == SNP_INV && (d.mval == META_A ||
                    (d.mval == META_I && d.opcode == OP_LINE_INV))) begin
                    d.act = '{1'b1, d.mval == META_A ? NDR_CMP_E : NDR_CMP, 1'b0,
                              ACT_INVAL, 1'b1, d.mval};
                end
            end
            OP_RD_DATA: begin
                if (d.snp == SNP_SHARED) begin
                    d.act = '{1'b1, d.prefer_excl ? NDR_CMP_E : NDR_CMP_S, 1'b1,
                              d.prefer_excl ? ACT_INVAL : ACT_SHARE,
                              d.meta_cur == META_I, META_A};
                end
            end
            default: d.act.legal = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// *** hdl/hrc_coherence_top.sv ***
/*
 * Device-side coherence engine for host memory requests, with APB registers.
 * Assumes request, response and device-agent ports come from logic on
 * core_clk; APB master on the same clock.
 */
`default_nettype none
module hrc_coherence_top
    import hrc_pkg::*;
#(
    parameter int LINES = 16,
    parameter int DATA_W = 64,
    parameter int TAG_W = 16,
    parameter int IDX_W = $clog2(LINES)
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [3:0] req_opcode,
    input wire logic [1:0] req_sel,
    input wire logic [1:0] req_mval,
    input wire logic [2:0] req_snp,
    input wire logic [TAG_W-1:0] req_tag,
    input wire logic [IDX_W-1:0] req_index,
    output logic ndr_valid,
    input wire logic ndr_ready,
    output logic [1:0] ndr_code,
    output logic [TAG_W-1:0] ndr_tag,
    output logic drs_valid,
    input wire logic drs_ready,
    output logic [TAG_W-1:0] drs_tag,
    output logic [DATA_W-1:0] drs_data,
    input wire logic dev_ask_valid,
    input wire logic dev_ask_excl,
    input wire logic [IDX_W-1:0] dev_ask_index,
    output logic dev_ask_local,
    output logic dev_ask_host,
    input wire logic dev_fill_valid,
    input wire logic [IDX_W-1:0] dev_fill_index,
    input wire logic [1:0] dev_fill_state,
    input wire logic [DATA_W-1:0] dev_fill_data
);
    // ----------------------------------------------------------------
    // line state
    // ----------------------------------------------------------------
    logic [1:0] meta_q [LINES];
    logic [1:0] cst_q [LINES];
    logic [DATA_W-1:0] cdat_q [LINES];
    logic [DATA_W-1:0] mem_q [LINES];
    hrc_state_type state_q;
    logic [1:0] ctrl_q;
    logic [15:0] err_cnt_q;
    logic [10:0] last_err_q;
    logic [IDX_W-1:0] peek_q;
    logic [IDX_W-1:0] cur_idx_q;
    logic ndr_pend_q;
    logic drs_pend_q;
    logic [1:0] ndr_code_q;
    logic [TAG_W-1:0] tag_q;
    logic [DATA_W-1:0] drs_data_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    hrc_action_type act;
    logic take;
    logic good;
    logic touch;
    logic [1:0] meta_at_req;
    logic [1:0] cst_at_req;
    logic [DATA_W-1:0] cdat_at_req;
    logic [DATA_W-1:0] mem_at_req;
    logic ndr_done;
    logic drs_done;

    hrc_dec_if dec_bus ();

    assign dec_bus.opcode = req_opcode;
    assign dec_bus.sel = req_sel;
    assign dec_bus.mval = req_mval;
    assign dec_bus.snp = req_snp;
    assign dec_bus.meta_cur = meta_at_req;
    assign dec_bus.prefer_excl = ctrl_q[CTRL_EXCL_BIT];
    assign act = dec_bus.act;

    hrc_decode u_decode (
        .d (dec_bus.decoder)
    );

    assign meta_at_req = meta_q[req_index];
    assign cst_at_req = cst_q[req_index];
    assign cdat_at_req = cdat_q[req_index];
    assign mem_at_req = mem_q[req_index];

    // ----------------------------------------------------------------
    // request handshake and response channels
    // ----------------------------------------------------------------
    assign req_ready = (state_q == ST_IDLE) && ctrl_q[CTRL_EN_BIT];
    assign take = req_valid && req_ready;
    assign good = take && act.legal;
    assign touch = good && act.act != ACT_KEEP;
    assign ndr_valid = ndr_pend_q;
    assign drs_valid = drs_pend_q;
    assign ndr_code = ndr_code_q;
    assign ndr_tag = tag_q;
    assign drs_tag = tag_q;
    assign drs_data = drs_data_q;
    assign ndr_done = !ndr_pend_q || ndr_ready;
    assign drs_done = !drs_pend_q || drs_ready;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        state_q <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    if (ndr_done && drs_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ndr_pend_q <= 1'b0;
            drs_pend_q <= 1'b0;
            ndr_code_q <= NDR_CMP;
            tag_q <= '0;
            cur_idx_q <= '0;
            drs_data_q <= '0;
        end else if (take) begin
            // every request gets a completion so the host can free its tag
            ndr_pend_q <= 1'b1;
            drs_pend_q <= act.legal && act.data;
            ndr_code_q <= act.legal ? act.no_data_response_channel : NDR_ERR;
            tag_q <= req_tag;
            cur_idx_q <= req_index;
            // a modified device copy is newer than memory
            drs_data_q <= (cst_at_req == CS_M) ? cdat_at_req : mem_at_req;
        end else begin
            if (ndr_ready) begin
                ndr_pend_q <= 1'b0;
            end
            if (drs_ready) begin
                drs_pend_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // host state metadata
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < LINES; i++) begin
                meta_q[i] <= META_I;
            end
        end else if (good && act.meta_wr) begin
            meta_q[req_index] <= act.meta_val;
        end
    end

    // ----------------------------------------------------------------
    // device cache and attached memory
    // ----------------------------------------------------------------
    // an invalidating snoop, or a sharing one to a line not invalid before, overrides the state of a fill to the same line in the same cycle;
    // the agent must refill if it still wants the line
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < LINES; i++) begin
                cst_q[i] <= CS_I;
                cdat_q[i] <= '0;
            end
        end else begin
            if (dev_fill_valid) begin
                cst_q[dev_fill_index] <= dev_fill_state;
                cdat_q[dev_fill_index] <= dev_fill_data;
            end
            if (touch && act.act == ACT_INVAL) begin
                cst_q[req_index] <= CS_I;
            end else if (touch && cst_at_req != CS_I) begin
                cst_q[req_index] <= CS_S;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < LINES; i++) begin
                mem_q[i] <= '0;
            end
        end else if (touch && cst_at_req == CS_M) begin
            mem_q[req_index] <= cdat_at_req;
        end
    end

    // ----------------------------------------------------------------
    // device agent copy requests
    // ----------------------------------------------------------------
    always_comb begin
        dev_ask_local = 1'b0;
        if (dev_ask_valid) begin
            case (meta_q[dev_ask_index])
                META_I: dev_ask_local = 1'b1;
                META_S: dev_ask_local = !dev_ask_excl;
                default: dev_ask_local = 1'b0;
            endcase
        end
    end
    assign dev_ask_host = dev_ask_valid && !dev_ask_local;

    // ----------------------------------------------------------------
    // apb registers
    // ----------------------------------------------------------------
    // read data is latched in the setup cycle, so pready can stay high
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
            if (paddr == REG_CTRL) begin
                prdata_q <= {30'h0, ctrl_q};
            end else if (paddr == REG_STATUS) begin
                prdata_q <= {5'h0, last_err_q, 15'h0, state_q == ST_RESP};
            end else if (paddr == REG_ERRCNT) begin
                prdata_q <= {16'h0, err_cnt_q};
            end else if (paddr == REG_PEEK) begin
                prdata_q <= {16'h0, 8'(peek_q), 4'h0, cst_q[peek_q], meta_q[peek_q]};
            end else begin
                pslverr_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
            peek_q <= '0;
        end else if (psel && penable && pwrite) begin
            if (paddr == REG_CTRL) begin
                ctrl_q <= pwdata[1:0];
            end else if (paddr == REG_PEEK) begin
                peek_q <= pwdata[IDX_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_cnt_q <= '0;
            last_err_q <= '0;
        end else begin
            if (take && !act.legal) begin
                last_err_q <= {req_opcode, req_sel, req_mval, req_snp};
            end
            // an error in the clearing cycle still counts
            if (psel && penable && pwrite && paddr == REG_ERRCNT) begin
                err_cnt_q <= (take && !act.legal) ? 16'h1 : 16'h0;
            end else if (take && !act.legal && err_cnt_q != 16'hffff) begin
                err_cnt_q <= err_cnt_q + 16'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_noop_keeps_meta: assert property (
        take && req_sel == SEL_NOOP && req_opcode == OP_LINE_RD
        |=> meta_q[cur_idx_q] == $past(meta_at_req))
        else $error("selector no-op changed host state");
    chk_invalid_local: assert property (
        dev_ask_valid && meta_q[dev_ask_index] == META_I |-> dev_ask_local && !dev_ask_host)
        else $error("invalid host state not served locally");
    chk_any_asks_host: assert property (
        dev_ask_valid && meta_q[dev_ask_index] == META_A |-> dev_ask_host && !dev_ask_local)
        else $error("any host state served without host");
    chk_shared_split: assert property (
        dev_ask_valid && meta_q[dev_ask_index] == META_S |-> dev_ask_host == dev_ask_excl)
        else $error("shared host state decision wrong");
    chk_reserved_snoop: assert property (
        take && req_snp[2] |=> ndr_valid && ndr_code == NDR_ERR && !drs_valid)
        else $error("reserved snoop kind not flagged");
    chk_read_any_inv: assert property (
        take && req_opcode == OP_LINE_RD && req_sel == SEL_HOST_STATE &&
        req_mval == META_A && req_snp == SNP_INV
        |=> ndr_valid && ndr_code == NDR_CMP_E && drs_valid && cst_q[cur_idx_q] == CS_I)
        else $error("exclusive read answered wrongly");
    chk_inv_plain: assert property (
        take && req_opcode == OP_LINE_INV && req_sel == SEL_HOST_STATE &&
        req_mval == META_I && req_snp == SNP_INV
        |=> ndr_code == NDR_CMP && !drs_valid && cst_q[cur_idx_q] == CS_I)
        else $error("invalidate with invalid state answered wrongly");
    chk_flush_dirty: assert property (
        take && act.legal && act.act == ACT_INVAL && cst_at_req == CS_M
        |=> mem_q[cur_idx_q] == $past(cdat_at_req))
        else $error("modified line not flushed to memory");
    chk_rfd_moves_any: assert property (
        take && req_opcode == OP_RD_DATA && req_snp == SNP_SHARED && meta_at_req == META_I
        |=> meta_q[cur_idx_q] == META_A && drs_valid)
        else $error("read_for_data did not move invalid to any");
    chk_current_keeps: assert property (
        take && act.legal && req_snp == SNP_CUR && !dev_fill_valid
        |=> cst_q[cur_idx_q] == $past(cst_at_req) && ndr_code == NDR_CMP)
        else $error("current snoop changed device state");
    chk_ndr_holds: assert property (
        ndr_valid && !ndr_ready |=> ndr_valid && $stable(ndr_code) && $stable(ndr_tag))
        else $error("completion dropped before acceptance");
    chk_drs_holds: assert property (
        drs_valid && !drs_ready |=> drs_valid && $stable(drs_data) && $stable(drs_tag))
        else $error("line data dropped before acceptance");
    chk_own_no_data: assert property (
        take && (req_opcode == OP_LINE_INV || req_opcode == OP_INV_NT) &&
        req_sel == SEL_HOST_STATE && req_mval == META_A && req_snp == SNP_INV
        |=> ndr_valid && ndr_code == NDR_CMP_E && !drs_valid)
        else $error("ownership grant answered wrongly");
    chk_err_counted: assert property (
        take && !act.legal && !(psel && penable && pwrite) && err_cnt_q != 16'hffff
        |=> err_cnt_q == $past(err_cnt_q) + 16'h1)
        else $error("protocol error not counted");

    cov_error_req: cover property (take && !act.legal);
    cov_read_data: cover property (take && act.legal && act.data ##[1:20] drs_valid && drs_ready);
    cov_flush: cover property (touch && cst_at_req == CS_M);
    cov_excl_grant: cover property (take && act.legal && act.no_data_response_channel == NDR_CMP_E && act.data);
endmodule
`default_nettype wire

// *** bench/hrc_host_model.sv ***
/* Host response sink for the coherence decoder bench.
   Assumes it shares core_clk and sys_rst with the device. */
`default_nettype none
module hrc_host_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic stall,
    input wire logic ndr_valid,
    input wire logic [17:0] ndr_info,
    input wire logic drs_valid,
    input wire logic [63:0] drs_data,
    input wire logic [15:0] drs_tag,
    output logic ndr_ready,
    output logic drs_ready,
    output logic [7:0] n_ndr,
    output logic [7:0] n_drs,
    output logic [17:0] got_ndr,
    output logic [63:0] got_data,
    output logic [15:0] got_dtag
);
    timeunit 1ns;
    timeprecision 100ps;
    // stall toggles ready so each channel sees wait cycles
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {ndr_ready, drs_ready, n_ndr, n_drs, got_ndr, got_data, got_dtag} <= '0;
        end else begin
            ndr_ready <= !stall || !ndr_ready;
            drs_ready <= !stall || !drs_ready;
            if (ndr_valid && ndr_ready) begin
                n_ndr <= n_ndr + 8'h01;
                got_ndr <= ndr_info;
            end
            // line data is only handed on, never kept as a cached copy
            if (drs_valid && drs_ready) begin
                n_drs <= n_drs + 8'h01;
                got_data <= drs_data;
                got_dtag <= drs_tag;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
/* Self-checking bench for the host request coherence decoder.
   Assumes default parameters: 16 lines, 64-bit data, 16-bit tags. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import hrc_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst, psel, penable, pwrite, pready, pslverr, stall, err, dev_ask_local;
    logic req_valid, req_ready, ndr_valid, ndr_ready, drs_valid, drs_ready, dev_fill_valid;
    logic dev_ask_valid, dev_ask_excl, dev_ask_host;
    logic [1:0] req_sel, req_mval, ndr_code, dev_fill_state;
    logic [2:0] req_snp;
    logic [3:0] req_opcode, req_index, dev_ask_index, dev_fill_index;
    logic [7:0] paddr, n_ndr, n_drs;
    logic [15:0] req_tag, ndr_tag, drs_tag, got_dtag;
    logic [17:0] got_ndr;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] drs_data, dev_fill_data, got_data;
    int n_fail = 0;
    int n_checks = 0;
    localparam logic [63:0] LA = 64'h0123456789abcdef;
    hrc_coherence_top dut (.*);
    hrc_host_model host (.ndr_info({ndr_code, ndr_tag}), .*);
    initial forever #2 core_clk = ~core_clk;
    initial begin
        #20000;
        n_fail++;
        complete_run();
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            n_fail++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic peek(input logic [3:0] idx);
        apb(1'b1, REG_PEEK, {28'h0, idx});
        apb(1'b0, REG_PEEK, 32'h0);
    endtask
    task automatic ask(input logic [3:0] idx, input logic ex, input logic loc);
        @(posedge core_clk);
        {dev_ask_valid, dev_ask_excl, dev_ask_index} <= {1'b1, ex, idx};
        @(negedge core_clk);
        check(dev_ask_local === loc && dev_ask_host === !loc, "device ask route");
    endtask
    task automatic fill(input logic [3:0] idx, input logic [1:0] st, input logic [63:0] d);
        @(posedge core_clk);
        {dev_fill_valid, dev_fill_index, dev_fill_state, dev_fill_data} <= {1'b1, idx, st, d};
        @(posedge core_clk);
        dev_fill_valid <= 1'b0;
    endtask
    // f is {opcode, selector, value, snoop}; ex is {data expected, completion code}
    task automatic rq(input logic [10:0] f, input logic [3:0] idx, input logic [2:0] ex,
            input logic [63:0] ev);
        logic [7:0] nd, nr;
        nd = n_ndr;
        nr = n_drs;
        @(posedge core_clk);
        {req_valid, req_opcode, req_sel, req_mval, req_snp, req_index} <= {1'b1, f, idx};
        req_tag <= req_tag + 16'h0011;
        do @(posedge core_clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do @(negedge core_clk); while (n_ndr === nd);
        // channels are unordered, so give the data channel time before judging it
        repeat (4) @(negedge core_clk);
        check(got_ndr === {ex[1:0], req_tag}, "completion code or tag");
        check((n_drs !== nr) === ex[2] && (!ex[2] || got_data === ev && got_dtag === req_tag),
            "data response");
    endtask
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, stall, dev_ask_valid, dev_ask_excl} = '0;
        {req_valid, req_opcode, req_sel, req_mval, req_snp, req_tag, req_index} = '0;
        {dev_ask_index, dev_fill_valid, dev_fill_index, dev_fill_state, dev_fill_data} = '0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        fill(4'h1, CS_M, LA);
        rq({4'h1, 2'h3, 2'h0, 3'h2}, 4'h1, 3'h4, LA);
        peek(4'h1);
        check(rd[3:0] === 4'hc, "device state kept");
        rq({4'h1, 2'h3, 2'h0, 3'h3}, 4'h1, 3'h4, LA);
        peek(4'h1);
        check(rd[3:2] === CS_I, "device copy dropped");
        rq({4'h1, 2'h0, 2'h3, 3'h1}, 4'h2, 3'h5, 64'h0);
        ask(4'h2, 1'b0, 1'b1);
        ask(4'h2, 1'b1, 1'b0);
        rq({4'h1, 2'h0, 2'h2, 3'h3}, 4'h3, 3'h6, 64'h0);
        ask(4'h3, 1'b0, 1'b0);
        rq({4'h0, 2'h0, 2'h2, 3'h3}, 4'h6, 3'h2, 64'h0);
        rq({4'h9, 2'h0, 2'h2, 3'h3}, 4'h7, 3'h2, 64'h0);
        fill(4'h5, CS_M, LA);
        rq({4'h0, 2'h0, 2'h0, 3'h3}, 4'h5, 3'h0, 64'h0);
        rq({4'h1, 2'h3, 2'h0, 3'h2}, 4'h5, 3'h4, LA);
        ask(4'h5, 1'b1, 1'b1);
        rq({4'h2, 2'h2, 2'h1, 3'h1}, 4'h4, 3'h5, 64'h0);
        peek(4'h4);
        check(rd[1:0] === META_A, "host state to any");
        rq({4'h1, 2'h1, 2'h3, 3'h1}, 4'h2, 3'h3, 64'h0);
        rq({4'h1, 2'h0, 2'h1, 3'h1}, 4'h2, 3'h3, 64'h0);
        rq({4'h1, 2'h3, 2'h0, 3'h4}, 4'h2, 3'h3, 64'h0);
        rq({4'h3, 2'h3, 2'h0, 3'h2}, 4'h2, 3'h3, 64'h0);
        apb(1'b0, REG_ERRCNT, 32'h0);
        check(rd === 32'h4, "error count");
        apb(1'b0, REG_STATUS, 32'h0);
        check(rd === 32'h01e20000, "last error fields");
        apb(1'b1, REG_ERRCNT, 32'h0);
        apb(1'b0, REG_ERRCNT, 32'h0);
        check(rd === 32'h0, "error count cleared");
        apb(1'b1, REG_CTRL, 32'h0);
        @(negedge core_clk);
        check(req_ready === 1'b0, "request taken while disabled");
        @(posedge core_clk);
        stall <= 1'b1;
        apb(1'b1, REG_CTRL, 32'h3);
        rq({4'h2, 2'h3, 2'h0, 3'h1}, 4'h8, 3'h6, 64'h0);
        rq({4'h1, 2'h0, 2'h3, 3'h1}, 4'h9, 3'h6, 64'h0);
        apb(1'b0, 8'h10, 32'h0);
        check(err === 1'b1 && rd === 32'h0, "unmapped address");
        complete_run();
    end
endmodule
`default_nettype wire
